// File: cfgrb_pkg.sv
// constants, types and defaults of the setup register bank
package cfgrb_pkg;

    localparam int CFGRB_NUM_WORDS = 7;
    localparam int CFGRB_WORD_W = 32;
    localparam int CFGRB_TAG_W = 8;
    localparam int CFGRB_ADDR_W = 3;

    // word offsets on the register port
    localparam logic [2:0] CFGRB_OFF_SETUP_0 = 3'h0;
    localparam logic [2:0] CFGRB_OFF_SETUP_1 = 3'h1;
    localparam logic [2:0] CFGRB_OFF_SETUP_3 = 3'h3;
    localparam logic [2:0] CFGRB_OFF_SETUP_4 = 3'h4;
    localparam logic [2:0] CFGRB_OFF_LAST = 3'h6;
    // read address that echoes the top byte of word 1
    localparam logic [2:0] CFGRB_OFF_ECHO = 3'h5;
    localparam logic [2:0] CFGRB_OFF_STATUS = 3'h7;

    // field positions
    localparam int CFGRB_TAG_LSB = 0;
    localparam int CFGRB_ECHO_LSB = 24;
    localparam int CFGRB_FIRST_WAVE_BIT = 30;
    localparam int CFGRB_AUTOCALC_BIT = 31;
    localparam int CFGRB_ERR_VAL_BIT = 29;
    localparam int CFGRB_DELAY_LSB = 8;
    localparam int CFGRB_DELAY_W = 16;
    localparam int CFGRB_STAT_POR_BIT = 0;
    localparam int CFGRB_STAT_FWM_BIT = 1;

    // values after reset, word 6 down to word 0
    localparam logic [31:0] CFGRB_RST_WORD_0 = 32'h22066800;
    localparam logic [31:0] CFGRB_RST_WORD_1 = 32'h55000000;
    localparam logic [31:0] CFGRB_RST_WORD_2 = 32'h20000000;
    localparam logic [31:0] CFGRB_RST_WORD_3 = 32'h18000000;
    localparam logic [31:0] CFGRB_RST_WORD_4 = 32'h00000000;
    localparam logic [31:0] CFGRB_RST_WORD_5 = 32'h00000000;
    localparam logic [31:0] CFGRB_RST_WORD_6 = 32'h00000000;
    localparam logic [6:0][31:0] CFGRB_RST_WORDS = {
        CFGRB_RST_WORD_6, CFGRB_RST_WORD_5, CFGRB_RST_WORD_4, CFGRB_RST_WORD_3,
        CFGRB_RST_WORD_2, CFGRB_RST_WORD_1, CFGRB_RST_WORD_0};
    localparam logic [31:0] CFGRB_RST_RDATA = 32'h00000000;
    localparam logic CFGRB_RST_POR_DONE = 1'b0;
    localparam logic CFGRB_RST_PIN_SYNC = 1'b1;

    // one request on the register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [31:0] wdata;
    } cfgrb_req_t;

    // decoded fields handed to the measurement logic
    typedef struct packed {
        logic autocalc_en;
        logic first_wave_en;
        logic err_val_en;
        logic [15:0] second_delay_value;
        logic [15:0] third_delay_value;
    } cfgrb_cfg_t;

endpackage : cfgrb_pkg

// File: cfgrb_sync.sv
// two-flop synchroniser for the external reset pin
`timescale 1ns/1ns
module cfgrb_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic async_in,
    output logic sync_q
);

    logic meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= cfgrb_pkg::CFGRB_RST_PIN_SYNC;
            sync_q <= cfgrb_pkg::CFGRB_RST_PIN_SYNC;
        end else if (ce) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule : cfgrb_sync

// File: cfgrb_word.sv
// one 32-bit setup word with default reload
`timescale 1ns/1ns
module cfgrb_word #(
    parameter logic [31:0] RST_VAL = 32'h00000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic load_dflt,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    output logic [31:0] word_q
);

    // whole word replaced at once, defaults win over a write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= RST_VAL;
        end else if (ce) begin
            if (load_dflt) begin
                word_q <= RST_VAL;
            end else if (wr_en) begin
                word_q <= wdata;
            end
        end
    end

endmodule : cfgrb_word

// File: cfgrb_bank.sv
// setup register bank: seven words, tag readback, mode decode
`timescale 1ns/1ns
module cfgrb_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reset_pin_n,
    input wire logic reset_cmd,
    input wire cfgrb_pkg::cfgrb_req_t bus_req,
    output logic [31:0] rdata_q,
    output logic [6:0][31:0] setup_words,
    output cfgrb_pkg::cfgrb_cfg_t cfg_fields
);

    logic [31:0] word_q [cfgrb_pkg::CFGRB_NUM_WORDS];
    logic pin_sync_q;
    logic load_dflt;
    logic por_done_q;
    logic [6:0] wr_sel;

    // true when the address names one of the setup words
    function automatic logic is_word_addr(input logic [2:0] addr);
        is_word_addr = (addr <= cfgrb_pkg::CFGRB_OFF_LAST);
    endfunction : is_word_addr

    // tag byte of a word placed in the low bits
    function automatic logic [31:0] tag_of(input logic [31:0] word);
        tag_of = {24'h000000, word[cfgrb_pkg::CFGRB_TAG_LSB +: cfgrb_pkg::CFGRB_TAG_W]};
    endfunction : tag_of

    // reset pin comes from outside the clock domain
    cfgrb_sync u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(reset_pin_n),
        .sync_q(pin_sync_q)
    );

    // pin or serial command both reload the defaults
    assign load_dflt = !pin_sync_q || reset_cmd;

    // write select per word, whole-word strobe
    always_comb begin
        wr_sel = 7'h00;
        if (bus_req.wr && is_word_addr(bus_req.addr)) begin
            wr_sel[bus_req.addr] = 1'b1;
        end
    end

    // the seven setup words
    for (genvar i = 0; i < cfgrb_pkg::CFGRB_NUM_WORDS; i++) begin : g_word
        cfgrb_word #(
            .RST_VAL(cfgrb_pkg::CFGRB_RST_WORDS[i])
        ) u_word (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .load_dflt(load_dflt),
            .wr_en(wr_sel[i]),
            .wdata(bus_req.wdata),
            .word_q(word_q[i])
        );
    end

    // full words to the measurement logic
    always_comb begin
        for (int k = 0; k < cfgrb_pkg::CFGRB_NUM_WORDS; k++) begin
            setup_words[k] = word_q[k];
        end
    end

    // decoded mode bits and delay fields
    always_comb begin
        cfg_fields.autocalc_en = word_q[3][cfgrb_pkg::CFGRB_AUTOCALC_BIT];
        cfg_fields.first_wave_en = word_q[3][cfgrb_pkg::CFGRB_FIRST_WAVE_BIT];
        cfg_fields.err_val_en = word_q[3][cfgrb_pkg::CFGRB_ERR_VAL_BIT];
        cfg_fields.second_delay_value =
            word_q[3][cfgrb_pkg::CFGRB_DELAY_LSB +: cfgrb_pkg::CFGRB_DELAY_W];
        cfg_fields.third_delay_value =
            word_q[4][cfgrb_pkg::CFGRB_DELAY_LSB +: cfgrb_pkg::CFGRB_DELAY_W];
    end

    // marks that the host gave the power-up reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_done_q <= cfgrb_pkg::CFGRB_RST_POR_DONE;
        end else if (ce) begin
            if (load_dflt) begin
                por_done_q <= 1'b1;
            end
        end
    end

    // read data one cycle after the strobe, setup bits hidden except the top byte of word 1 at the echo address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= cfgrb_pkg::CFGRB_RST_RDATA;
        end else if (ce) begin
            if (!bus_req.rd) begin
                rdata_q <= cfgrb_pkg::CFGRB_RST_RDATA;
            end else if (bus_req.addr == cfgrb_pkg::CFGRB_OFF_ECHO) begin
                rdata_q <= {24'h000000,
                    word_q[1][cfgrb_pkg::CFGRB_ECHO_LSB +: cfgrb_pkg::CFGRB_TAG_W]};
            end else if (is_word_addr(bus_req.addr)) begin
                rdata_q <= tag_of(word_q[bus_req.addr]);
            end else if (bus_req.addr == cfgrb_pkg::CFGRB_OFF_STATUS) begin
                rdata_q <= 32'h00000000;
                rdata_q[cfgrb_pkg::CFGRB_STAT_POR_BIT] <= por_done_q;
                rdata_q[cfgrb_pkg::CFGRB_STAT_FWM_BIT] <= cfg_fields.first_wave_en;
            end else begin
                rdata_q <= cfgrb_pkg::CFGRB_RST_RDATA;
            end
        end
    end

    // checks

    logic [31:0] word3_past;
    logic [31:0] word1_past;

    // snapshot of words seen one cycle earlier
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word3_past <= cfgrb_pkg::CFGRB_RST_WORD_3;
            word1_past <= cfgrb_pkg::CFGRB_RST_WORD_1;
        end else begin
            word3_past <= word_q[3];
            word1_past <= word_q[1];
        end
    end

    property p_word_write(logic [2:0] a, int idx);
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.wr && bus_req.addr == a && !load_dflt)
            |=> (word_q[idx] == $past(bus_req.wdata));
    endproperty

    a_word3_whole_write: assert property (p_word_write(3'h3, 3))
        else $error("word 3 not replaced by write");

    a_word6_whole_write: assert property (p_word_write(3'h6, 6))
        else $error("word 6 not replaced by write");

    a_echo_top_byte: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.rd && bus_req.addr == cfgrb_pkg::CFGRB_OFF_ECHO)
            |=> (rdata_q == {24'h000000, word1_past[31:24]}))
        else $error("echo address did not return word 1 top byte");

    a_tag_read_back: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.rd && bus_req.addr == 3'h3)
            |=> (rdata_q[7:0] == word3_past[7:0]))
        else $error("tag of word 3 not read back");

    a_setup_bits_hidden: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.rd && bus_req.addr != cfgrb_pkg::CFGRB_OFF_ECHO)
            |=> (rdata_q[31:8] == 24'h000000))
        else $error("setup bits leaked on read");

    a_first_wave_mode: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == 3'h3 && bus_req.wdata[30])
            |=> (cfg_fields.first_wave_en
                && cfg_fields.second_delay_value == $past(bus_req.wdata[23:8])))
        else $error("first wave mode not entered");

    a_ext_enables: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == 3'h3)
            |=> (cfg_fields.autocalc_en == $past(bus_req.wdata[31])))
        else $error("word 3 bit 31 enable not taken");

    a_defaults_reload: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && reset_cmd)
            |=> (setup_words == cfgrb_pkg::CFGRB_RST_WORDS && rdata_q[7:0] == 8'h00
                || $past(bus_req.rd)))
        else $error("defaults not reloaded");

    a_unmapped_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == cfgrb_pkg::CFGRB_OFF_STATUS)
            |=> $stable(setup_words))
        else $error("write to address 7 changed a word");

    a_reset_seen_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && reset_cmd) |=> por_done_q [*2])
        else $error("power-up reset flag not held");

    a_freeze_on_ce: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!ce) |=> ($stable(setup_words) && $stable(rdata_q)))
        else $error("state moved while clock enable low");

    // every word takes a write whole
    a_word0_whole_write: assert property (p_word_write(3'h0, 0))
        else $error("word 0 not replaced by write");

    a_word1_whole_write: assert property (p_word_write(3'h1, 1))
        else $error("word 1 not replaced by write");

    a_word2_whole_write: assert property (p_word_write(3'h2, 2))
        else $error("word 2 not replaced by write");

    a_word4_whole_write: assert property (p_word_write(3'h4, 4))
        else $error("word 4 not replaced by write");

    a_word5_whole_write: assert property (p_word_write(3'h5, 5))
        else $error("word 5 not replaced by write");

    // a write to word 1 leaves words 0, 2 and 3 alone
    a_others_untouched: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == cfgrb_pkg::CFGRB_OFF_SETUP_1)
            |=> ($stable(word_q[0]) && $stable(word_q[2]) && $stable(word_q[3])))
        else $error("write to word 1 changed another word");

    // read data fall back to zero without a strobe
    a_read_idle_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !bus_req.rd) |=> (rdata_q == cfgrb_pkg::CFGRB_RST_RDATA))
        else $error("read data stood without a read strobe");

    // tag bytes of words 0, 2 and 6 come back
    a_tag_word0_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.rd && bus_req.addr == cfgrb_pkg::CFGRB_OFF_SETUP_0)
            |=> (rdata_q[7:0] == $past(word_q[0][7:0])))
        else $error("tag of word 0 not read back");

    a_tag_word2_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.rd && bus_req.addr == 3'h2)
            |=> (rdata_q[7:0] == $past(word_q[2][7:0])))
        else $error("tag of word 2 not read back");

    a_tag_word6_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.rd && bus_req.addr == cfgrb_pkg::CFGRB_OFF_LAST)
            |=> (rdata_q[7:0] == $past(word_q[6][7:0])))
        else $error("tag of word 6 not read back");

    // status word: power-up reset seen, first wave mode
    a_status_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.rd && bus_req.addr == cfgrb_pkg::CFGRB_OFF_STATUS)
            |=> (rdata_q == {30'h0000000, $past(cfg_fields.first_wave_en), $past(por_done_q)}))
        else $error("status word wrong");

    // synchronised pin low reloads every word
    a_pin_reload: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !pin_sync_q) |=> (setup_words == cfgrb_pkg::CFGRB_RST_WORDS))
        else $error("pin reset did not reload defaults");

    // any power-up reset marks the status flag
    a_por_flag_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && load_dflt) |=> por_done_q)
        else $error("power-up reset flag not set");

    // mode bits and delay fields follow the written word
    a_err_val_decode: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == cfgrb_pkg::CFGRB_OFF_SETUP_3)
            |=> (cfg_fields.err_val_en == $past(bus_req.wdata[29])))
        else $error("word 3 bit 29 not taken");

    a_second_delay_field: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == cfgrb_pkg::CFGRB_OFF_SETUP_3)
            |=> (cfg_fields.second_delay_value == $past(bus_req.wdata[23:8])))
        else $error("second delay value not taken");

    a_third_delay_field: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == cfgrb_pkg::CFGRB_OFF_SETUP_4)
            |=> (cfg_fields.third_delay_value == $past(bus_req.wdata[23:8])))
        else $error("third delay value not taken");

    a_first_wave_off: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == cfgrb_pkg::CFGRB_OFF_SETUP_3
            && !bus_req.wdata[30]) |=> !cfg_fields.first_wave_en)
        else $error("first wave mode not left");

    a_word4_keeps_modes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !load_dflt && bus_req.wr && bus_req.addr == cfgrb_pkg::CFGRB_OFF_SETUP_4)
            |=> ($stable(cfg_fields.first_wave_en) && $stable(cfg_fields.autocalc_en)))
        else $error("write to word 4 moved a mode bit");

    c_comm_test: cover property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.wr && bus_req.addr == 3'h1)
            ##1 (ce && bus_req.rd && bus_req.addr == cfgrb_pkg::CFGRB_OFF_ECHO));

    c_first_wave_on: cover property (
        @(posedge clk) disable iff (!rst_n)
        $rose(cfg_fields.first_wave_en));

    c_pin_reset: cover property (
        @(posedge clk) disable iff (!rst_n)
        $fell(pin_sync_q));

    c_back_to_back: cover property (
        @(posedge clk) disable iff (!rst_n)
        (ce && bus_req.wr) ##1 (ce && bus_req.rd) ##1 (ce && bus_req.wr));

endmodule : cfgrb_bank

// File: cfgrb_host.sv
// host model driving the setup register port and the reset lines
`timescale 1ns/1ns
module cfgrb_host (
    input wire logic clk,
    input wire logic [31:0] rdata_q,
    output cfgrb_pkg::cfgrb_req_t bus_req,
    output logic reset_pin_n,
    output logic reset_cmd
);
    // quiet lines at time zero
    initial begin
        bus_req = '0;
        reset_pin_n = 1'b1;
        reset_cmd = 1'b0;
    end
    // one write strobe; next request or idle follows at the next edge
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= {2'b10, a, d};
    endtask : wr
    // drop strobes; stale address and data inverted so no old value lingers
    task automatic idle();
        @(posedge clk);
        bus_req <= {2'b00, ~bus_req.addr, ~bus_req.wdata};
        #1;
    endtask : idle
    // one read strobe, data taken in the cycle after
    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_req <= {2'b01, a, ~bus_req.wdata};
        idle();
        d = rdata_q;
    endtask : rd
    // power-up reset by command pulse of one cycle
    task automatic cmd_reset();
        @(posedge clk);
        reset_cmd <= 1'b1;
        @(posedge clk);
        reset_cmd <= 1'b0;
        #1;
    endtask : cmd_reset
    // power-up reset by pin, held four cycles, synchroniser given time
    task automatic pin_reset();
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : pin_reset
endmodule : cfgrb_host

// File: cfgrb_bank_tb.sv
// self-checking bench of the setup register bank
`timescale 1ns/1ns
module cfgrb_bank_tb;
    typedef struct packed {
        logic [2:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } cfgrb_row_t;
    logic clk;
    logic rst_n;
    logic ce;
    cfgrb_pkg::cfgrb_req_t bus_req;
    logic reset_pin_n;
    logic reset_cmd;
    logic [31:0] rdata_q;
    logic [31:0] rv;
    logic [6:0][31:0] setup_words;
    logic [6:0][31:0] exp_w;
    cfgrb_pkg::cfgrb_cfg_t cfg_fields;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    // word written, read answer expected; row 5 echoes word 1 top byte
    cfgrb_row_t rows [7] = '{
        '{3'h0, 32'h22066801, 32'h00000001}, '{3'h1, 32'hA7000012, 32'h00000012},
        '{3'h2, 32'h20000023, 32'h00000023}, '{3'h3, 32'h18123434, 32'h00000034},
        '{3'h4, 32'h00567845, 32'h00000045}, '{3'h5, 32'h00000056, 32'h000000A7},
        '{3'h6, 32'h00000067, 32'h00000067}};

    cfgrb_bank cfgrb_bank_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .reset_pin_n(reset_pin_n),
        .reset_cmd(reset_cmd), .bus_req(bus_req), .rdata_q(rdata_q), .setup_words(setup_words),
        .cfg_fields(cfg_fields));
    cfgrb_host cfgrb_host_inst (.clk(clk), .rdata_q(rdata_q), .bus_req(bus_req),
        .reset_pin_n(reset_pin_n), .reset_cmd(reset_cmd));

    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            wrap_up();
        end
    end
    // one comparison
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // all seven words against the expected copy
    task automatic chk_words();
        for (int i = 0; i < 7; i++) begin
            chk("setup word", exp_w[i], setup_words[i]);
        end
    endtask : chk_words
    // single write, then idle; expected copy follows
    task automatic wrx(input logic [2:0] a, input logic [31:0] d);
        cfgrb_host_inst.wr(a, d);
        cfgrb_host_inst.idle();
        if (a != 3'h7) begin
            exp_w[a] = d;
        end
    endtask : wrx
    // counts and verdict
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        exp_w = cfgrb_pkg::CFGRB_RST_WORDS;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk_words();
        cfgrb_host_inst.rd(3'h0, rv);
        chk("tag after reset", 32'h00000000, rv);
        cfgrb_host_inst.cmd_reset();
        $display("test reset done");
        // table rows, upper bits of word 0 kept at defaults
        foreach (rows[i]) begin
            wrx(rows[i].addr, rows[i].wdata);
            chk_words();
            cfgrb_host_inst.rd(rows[i].addr, rv);
            chk("read back", rows[i].rexp, rv);
        end
        $display("test rows done");
        // back-to-back writes into the mode words
        cfgrb_host_inst.wr(3'h3, 32'hC0ABCD11);
        cfgrb_host_inst.wr(3'h4, 32'h00BEEF22);
        cfgrb_host_inst.idle();
        exp_w[3] = 32'hC0ABCD11;
        exp_w[4] = 32'h00BEEF22;
        chk_words();
        chk("first wave", 32'h1, {31'h0, cfg_fields.first_wave_en});
        chk("ext enable", 32'h1, {31'h0, cfg_fields.autocalc_en});
        chk("error value", 32'h0, {31'h0, cfg_fields.err_val_en});
        chk("second delay", 32'h0000ABCD, {16'h0, cfg_fields.second_delay_value});
        chk("third delay", 32'h0000BEEF, {16'h0, cfg_fields.third_delay_value});
        cfgrb_host_inst.rd(3'h7, rv);
        chk("status", 32'h00000003, rv);
        $display("test first wave done");
        // write beyond the seven words, then read with data gone next cycle
        wrx(3'h7, 32'hFFFFFFFF);
        chk_words();
        cfgrb_host_inst.rd(3'h3, rv);
        chk("tag word 3", 32'h00000011, rv);
        @(posedge clk);
        #1;
        chk("read idle", 32'h00000000, rdata_q);
        // write word 1 and read the echo at once
        cfgrb_host_inst.wr(3'h1, 32'h3C0000AA);
        exp_w[1] = 32'h3C0000AA;
        cfgrb_host_inst.rd(3'h5, rv);
        chk("echo", 32'h0000003C, rv);
        $display("test edge cases done");
        // power-up reset by command and by pin reload defaults
        cfgrb_host_inst.cmd_reset();
        exp_w = cfgrb_pkg::CFGRB_RST_WORDS;
        chk_words();
        wrx(3'h2, 32'h5A5A5A5A);
        cfgrb_host_inst.pin_reset();
        exp_w = cfgrb_pkg::CFGRB_RST_WORDS;
        chk_words();
        cfgrb_host_inst.rd(3'h2, rv);
        chk("tag after pin reset", 32'h00000000, rv);
        $display("test power-up reset done");
        // clock enable low: a write is refused, state frozen
        @(posedge clk);
        ce <= 1'b0;
        cfgrb_host_inst.wr(3'h0, 32'h220668EE);
        cfgrb_host_inst.idle();
        @(posedge clk);
        ce <= 1'b1;
        #1;
        chk_words();
        $display("test clock enable done");
        // reset in mid-run: defaults back, power-up flag cleared
        wrx(3'h4, 32'h00123456);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        exp_w = cfgrb_pkg::CFGRB_RST_WORDS;
        chk_words();
        cfgrb_host_inst.rd(3'h7, rv);
        chk("status after reset", 32'h00000000, rv);
        cfgrb_host_inst.cmd_reset();
        cfgrb_host_inst.rd(3'h7, rv);
        chk("status after command", 32'h00000001, rv);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule : cfgrb_bank_tb
